// file: hw/gcb_global_control_bank.v
// Global control register bank with loopback policy and LED mapping.
`default_nettype none
`include "gcb_defs.vh"

// Notes on behaviour
// RULE_01: Factory test byte at 0x0A, resets 0x24.
// RULE_02: Control bit 6 enables PHY power saving.
// RULE_03: Error-drop set: drop OAM and errored frames.
// RULE_04: Error-drop clear: drop OAM, loop all others.
// RULE_05: Loop position code 1 0 selects port-two MAC.
// RULE_06: Loop high resets 1; low from strap.
// RULE_07: LED mode bit drives low select only.
// RULE_08: LED select chooses per-port indicator meanings.
// RULE_09: Byte 0x0C reserved, reads 0x00.
// RULE_10: Three scratch bytes 0x0D-0x0F, reset 0x00.
// RULE_11: Control bits 7 and 0 read zero.
module gcb_global_control_bank (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register access
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Strap pins
  input wire loop_position_strap,
  input wire error_drop_strap,
  input wire led_select_high_strap,
  // Frame classification from the datapath
  input wire frame_valid,
  input wire frame_is_oam,
  input wire frame_crc_err,
  input wire frame_undersize,
  input wire frame_oversize,
  output wire frame_drop,
  output wire frame_loop,
  // Steering outputs
  output wire phy_power_save,
  output wire loop_at_port2_mac,
  output wire test_mode,
  output wire led_select_low,
  output wire led_select_high,
  // Per-port status and indicators
  input wire link_up,
  input wire activity,
  input wire full_duplex,
  input wire collision,
  input wire speed_100,
  output reg port_indicator_0,
  output reg port_indicator_1,
  output reg port_indicator_2,
  output reg port_indicator_3
);

  // ==========================================================
  // Strap synchronisers and capture on the third clock after reset release
  // ==========================================================
  reg [2:0] strap_s1_q;
  reg [2:0] strap_s2_q;
  reg strap_done_q;
  reg led_high_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
    end else begin
      strap_s1_q <= {led_select_high_strap, error_drop_strap, loop_position_strap};
      strap_s2_q <= strap_s1_q;
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  reg [7:0] factory_q;
  reg [7:0] control_q;
  reg [7:0] scratch1_q;
  reg [7:0] scratch2_q;
  reg [7:0] scratch3_q;
  // Strap-loaded bits are taken once, when the synchroniser has settled after reset.
  reg [1:0] settle_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      factory_q <= `GCB_RST_FACTORY; // RULE_01
      control_q <= `GCB_RST_CONTROL; // RULE_06
      scratch1_q <= `GCB_RST_SCRATCH; // RULE_10
      scratch2_q <= `GCB_RST_SCRATCH;
      scratch3_q <= `GCB_RST_SCRATCH;
      settle_q <= 2'h0;
      strap_done_q <= 1'b0;
      led_high_q <= 1'b0;
    end else begin
      // The strap load comes first so that a write to the control byte in the
      // same cycle overrides the strapped bits.
      if (!strap_done_q) begin
        settle_q <= settle_q + 2'h1;
        if (settle_q == `GCB_STRAP_SETTLE) begin
          strap_done_q <= 1'b1;
          control_q[`GCB_BIT_LOOP_LOW] <= strap_s2_q[0]; // RULE_06
          control_q[`GCB_BIT_ERROR_DROP] <= strap_s2_q[1];
          led_high_q <= strap_s2_q[2]; // RULE_07
        end
      end
      if (reg_wr) begin
        case (reg_addr)
          `GCB_OFS_FACTORY: begin
            factory_q <= reg_wdata; // RULE_01
          end
          `GCB_OFS_CONTROL: begin
            control_q <= reg_wdata & `GCB_CONTROL_MASK; // RULE_11
          end
          `GCB_OFS_SCRATCH1: begin
            scratch1_q <= reg_wdata; // RULE_10
          end
          `GCB_OFS_SCRATCH2: begin
            scratch2_q <= reg_wdata; // RULE_10
          end
          `GCB_OFS_SCRATCH3: begin
            scratch3_q <= reg_wdata; // RULE_10
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  // Reads are combinational, so the addressed value stands as long as the address.
  always @* begin
    case (reg_addr)
      `GCB_OFS_FACTORY: begin
        reg_rdata = factory_q; // RULE_01
      end
      `GCB_OFS_CONTROL: begin
        reg_rdata = control_q & `GCB_CONTROL_MASK; // RULE_11
      end
      `GCB_OFS_RESERVED: begin
        reg_rdata = `GCB_RST_RESERVED; // RULE_09
      end
      `GCB_OFS_SCRATCH1: begin
        reg_rdata = scratch1_q; // RULE_10
      end
      `GCB_OFS_SCRATCH2: begin
        reg_rdata = scratch2_q; // RULE_10
      end
      `GCB_OFS_SCRATCH3: begin
        reg_rdata = scratch3_q; // RULE_10
      end
      default: begin
        reg_rdata = `GCB_RST_UNMAPPED;
      end
    endcase
  end

  // ==========================================================
  // Control field views
  // ==========================================================
  wire ctl_power_save = control_q[`GCB_BIT_POWER_SAVE];
  wire ctl_test_mode = control_q[`GCB_BIT_TEST_MODE];
  wire [1:0] ctl_loop_code = {control_q[`GCB_BIT_LOOP_HIGH], control_q[`GCB_BIT_LOOP_LOW]};
  wire ctl_led_mode = control_q[`GCB_BIT_LED_MODE];

  // ==========================================================
  // Steering and frame policy
  // ==========================================================
  assign phy_power_save = ctl_power_save; // RULE_02
  // The test-mode bit is stored and shown; software is expected to keep it clear.
  assign test_mode = ctl_test_mode; // RULE_11
  // Only code 1 0 is defined; reserved codes select no loopback point.
  assign loop_at_port2_mac = (ctl_loop_code == `GCB_LOOP_PORT2_MAC); // RULE_05
  // OAM frames are always dropped; errored frames only when error-drop is set.
  wire frame_err = frame_crc_err | frame_undersize | frame_oversize;
  wire drop_err = control_q[`GCB_BIT_ERROR_DROP];
  assign frame_drop = frame_valid & (frame_is_oam | (drop_err & frame_err)); // RULE_03 RULE_04
  assign frame_loop = frame_valid & loop_at_port2_mac & ~frame_drop; // RULE_03 RULE_04

  // ==========================================================
  // LED mapping
  // ==========================================================
  // Indicators are registered so that they change only on the clock.
  assign led_select_low = ctl_led_mode; // RULE_07
  assign led_select_high = led_high_q; // RULE_07
  wire [1:0] led_sel = {led_select_high, led_select_low};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      port_indicator_0 <= 1'b0;
      port_indicator_1 <= 1'b0;
      port_indicator_2 <= 1'b0;
      port_indicator_3 <= 1'b0;
    end else begin
      case (led_sel) // RULE_08
        2'h0: begin
          port_indicator_3 <= 1'b0;
          port_indicator_2 <= link_up & ~activity;
          port_indicator_1 <= full_duplex & ~collision;
          port_indicator_0 <= speed_100;
        end
        2'h1: begin
          port_indicator_3 <= 1'b0;
          port_indicator_2 <= link_up & speed_100 & ~activity;
          port_indicator_1 <= link_up & ~speed_100 & ~activity;
          port_indicator_0 <= full_duplex;
        end
        2'h2: begin
          port_indicator_3 <= activity;
          port_indicator_2 <= link_up;
          port_indicator_1 <= full_duplex & ~collision;
          port_indicator_0 <= speed_100;
        end
        // Code 1 1 has no defined meaning, so all indicators stay dark.
        default: begin
          port_indicator_3 <= 1'b0;
          port_indicator_2 <= 1'b0;
          port_indicator_1 <= 1'b0;
          port_indicator_0 <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: hw/gcb_defs.vh
// Offsets, field positions and reset values of the global control bank.
`ifndef GCB_DEFS_VH
`define GCB_DEFS_VH
`define GCB_OFS_FACTORY 8'h0A
`define GCB_OFS_CONTROL 8'h0B
`define GCB_OFS_RESERVED 8'h0C
`define GCB_OFS_SCRATCH1 8'h0D
`define GCB_OFS_SCRATCH2 8'h0E
`define GCB_OFS_SCRATCH3 8'h0F
`define GCB_RST_FACTORY 8'h24
`define GCB_RST_SCRATCH 8'h00
`define GCB_RST_RESERVED 8'h00
`define GCB_RST_CONTROL 8'h08
`define GCB_RST_UNMAPPED 8'h00
`define GCB_CONTROL_MASK 8'h7E
`define GCB_STRAP_SETTLE 2'h2
`define GCB_BIT_POWER_SAVE 6
`define GCB_BIT_ERROR_DROP 5
`define GCB_BIT_TEST_MODE 4
`define GCB_BIT_LOOP_HIGH 3
`define GCB_BIT_LOOP_LOW 2
`define GCB_BIT_LED_MODE 1
`define GCB_LOOP_PORT2_MAC 2'h2
`endif

// file: tb/gcb_bank_props.sv
// Concurrent checks on the global control bank ports.
`default_nettype none
module gcb_bank_props (
  input wire logic clk, rst, reg_wr, frame_valid, frame_is_oam,
  input wire logic frame_crc_err, frame_undersize, frame_oversize,
  input wire logic frame_drop, frame_loop, phy_power_save, loop_at_port2_mac, led_select_low,
  input wire logic test_mode,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire err = frame_crc_err | frame_undersize | frame_oversize;
  sequence ctl_wr; reg_wr && reg_addr == 8'h0B; endsequence
  sequence scr_wr; reg_wr && reg_addr == 8'h0D ##1 reg_addr == 8'h0D; endsequence
  AST_PWR: assert property (ctl_wr |=> phy_power_save == $past(reg_wdata[6]))
    else $error("power");
  AST_LEDL: assert property (ctl_wr |=> led_select_low == $past(reg_wdata[1]))
    else $error("ledsel");
  AST_LOOP: assert property (ctl_wr |=> loop_at_port2_mac == ($past(reg_wdata[3:2]) == 2'h2))
    else $error("loop");
  AST_OAM: assert property (frame_valid && frame_is_oam |-> frame_drop)
    else $error("oam");
  AST_GOOD: assert property (frame_valid && !frame_is_oam && !err |-> !frame_drop)
    else $error("good");
  AST_FLP: assert property (frame_loop |-> loop_at_port2_mac && !frame_drop)
    else $error("floop");
  AST_RSV: assert property (reg_addr == 8'h0C |-> reg_rdata == 8'h00)
    else $error("rsvd");
  AST_B70: assert property (reg_addr == 8'h0B |-> !reg_rdata[7] && !reg_rdata[0])
    else $error("ctl");
  AST_SCR: assert property (scr_wr |-> reg_rdata == $past(reg_wdata))
    else $error("scratch");
  AST_TST: assert property (ctl_wr |=> test_mode == $past(reg_wdata[4]))
    else $error("testmode");
endmodule
`default_nettype wire

// file: tb/gcb_global_control_bank_tb_top.sv
// Self-checking bench for the global control bank.
`default_nettype none
module gcb_global_control_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, dr, lk;
  logic led_strap = 1'h0, drop_strap = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
  logic [4:0] fr = 5'h00, st = 5'h00;
  logic [1:0] knd = 2'h0;
  wire [7:0] rdata;
  wire drop, loop, i0, i1, i2, i3;
  int errors = 0, tests_run = 0;
  logic [7:0] q[$];
  initial forever #50 clk = ~clk;
  gcb_global_control_bank u_gcb_global_control_bank (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
    .loop_position_strap(1'h0),
    .error_drop_strap(drop_strap), .led_select_high_strap(led_strap), .frame_valid(fr[4]),
    .frame_is_oam(fr[3]), .frame_crc_err(fr[2]), .frame_undersize(fr[1]),
    .frame_oversize(fr[0]), .frame_drop(drop), .frame_loop(loop), .phy_power_save(),
    .loop_at_port2_mac(), .test_mode(), .led_select_low(), .led_select_high(),
    .link_up(st[4]), .activity(st[3]), .full_duplex(st[2]), .collision(st[1]),
    .speed_100(st[0]), .port_indicator_0(i0), .port_indicator_1(i1), .port_indicator_2(i2),
    .port_indicator_3(i3));
  task automatic cmp_sig(input logic [7:0] g, x);
    tests_run++;
    if (g !== x) begin
      errors++;
      $display("mismatch %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic cmp_reg(input logic [7:0] x);
    cmp_sig(rdata, x);
  endtask
  task automatic put(input logic [1:0] k, input logic [7:0] x);
    q.push_back(x);
    knd = k;
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'h1;
    @(negedge clk);
    reg_wr = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, x);
    reg_addr = a;
    put(2'h0, x);
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (q.size() > 0) begin
      if (knd == 2'h0) cmp_reg(q.pop_front());
      else cmp_sig(knd == 2'h1 ? {6'h00, drop, loop} : {4'h0, i3, i2, i1, i0}, q.pop_front());
    end
  end
  initial begin
    #2000000;
    errors++;
    report_and_stop;
  end
  initial begin
    void'($urandom(75129));
    repeat (16) @(negedge clk);
    rst = 1'h0;
    repeat (4) @(negedge clk);
    rd(8'h0A, 8'h24);
    rd(8'h0B, 8'h08);
    for (int a = 13; a < 16; a++) begin
      d = 8'($urandom);
      rd(a[7:0], 8'h00);
      wr(a[7:0], d);
      rd(a[7:0], d);
    end
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'h0B, 8'hE9);
    rd(8'h0B, 8'h68);
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      wr(8'h0B, m ? 8'h08 : 8'h28);
      for (int f = 0; f < 32; f++) begin
        fr = f[4:0];
        dr = fr[4] & (fr[3] | (m == 0 && fr[2:0] != 3'h0));
        put(2'h1, {6'h00, dr, fr[4] & ~dr});
      end
    end
    $display("test frames done");
    for (int m = 0; m < 4; m++) begin
      if (m == 2) begin
        rst = 1'h1;
        led_strap = 1'h1;
        drop_strap = 1'h1;
        repeat (16) @(negedge clk);
        rst = 1'h0;
        repeat (4) @(negedge clk);
        rd(8'h0B, 8'h28);
      end
      wr(8'h0B, {6'h02, m[0], 1'h0});
      repeat (8) begin
        st = 5'($urandom);
        @(negedge clk);
        lk = st[4] & ~st[3];
        case (m)
          0: d = {5'h00, lk, st[2] & ~st[1], st[0]};
          1: d = {5'h00, lk & st[0], lk & ~st[0], st[2]};
          2: d = {4'h0, st[3], st[4], st[2] & ~st[1], st[0]};
          default: d = 8'h00;
        endcase
        put(2'h2, d);
      end
    end
    $display("test indicators done");
    @(negedge clk);
    report_and_stop;
  end
endmodule
bind gcb_global_control_bank gcb_bank_props u_gcb_bank_props (.clk(clk), .rst(rst),
  .reg_wr(reg_wr), .frame_valid(frame_valid), .frame_is_oam(frame_is_oam),
  .frame_crc_err(frame_crc_err), .frame_undersize(frame_undersize),
  .frame_oversize(frame_oversize), .frame_drop(frame_drop), .frame_loop(frame_loop),
  .phy_power_save(phy_power_save), .loop_at_port2_mac(loop_at_port2_mac),
  .led_select_low(led_select_low), .test_mode(test_mode), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata));
`default_nettype wire
